/* File: common/ext_irq_pkg.sv */
package ext_irq_pkg;

    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] IDX_FALL_A  = 8'hBA;
    localparam logic [7:0] IDX_RISE_A  = 8'hBB;
    localparam logic [7:0] IDX_FALL_B  = 8'hBC;
    localparam logic [7:0] IDX_RISE_B  = 8'hBD;
    localparam logic [7:0] IDX_FALL_C  = 8'hC6;
    localparam logic [7:0] IDX_RISE_C  = 8'hC7;
    localparam logic [7:0] IDX_FLAGS   = 8'h88;
    localparam logic [7:0] IDX_IRQ_EN2 = 8'hA9;
    localparam logic [7:0] IDX_STATUS  = 8'hD0;
    localparam logic [7:0] IDX_MASK    = 8'hD1;

    // ****************************************
    // Widths, fields, reset values
    // ****************************************
    localparam int ADDR_W      = 12;
    localparam int LINES_A     = 4;
    localparam int LINES_B     = 4;
    localparam int LINES_C     = 6;
    localparam int LINES_ALL   = LINES_A + LINES_B + LINES_C;
    localparam int FLAG_A_BIT  = 1;
    localparam int FLAG_B_BIT  = 3;
    localparam int EN_C_BIT    = 3;
    localparam int ST_A        = 0;
    localparam int ST_B        = 1;
    localparam int ST_C        = 2;
    localparam int STAT_W      = 3;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

endpackage : ext_irq_pkg

/* File: logic/ext_irq_edge_select.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ps

// How it works
// - Group A has four falling-edge enables in bits 3..0, one per line.
// - Group A has four rising-edge enables in bits 3..0, one per line.
// - Group B has four falling-edge enables in bits 3..0, one per line.
// - Group B has four rising-edge enables in bits 3..0, one per line.
// - Group C has six falling-edge enables in bits 5..0, one per line.
// - Group C has six rising-edge enables in bits 5..0, one per line.
// - Armed edge on group B sets its flag, bit 3; CPU response clears it.
// - Armed edge on group A sets its flag, bit 1; CPU vectoring clears it.
// - Group C requests reach reqC only while its enable bit 3 is set; its status bit still drives irq through the mask alone.
module ext_irq_edge_select
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // External interrupt pins
    input  wire logic [LINES_A-1:0]  extGroupA,
    input  wire logic [LINES_B-1:0]  extGroupB,
    input  wire logic [LINES_C-1:0]  extGroupC,
    // CPU interrupt logic
    input  wire logic                ackA,
    input  wire logic                ackB,
    input  wire logic                ackC,
    output logic                     reqA,
    output logic                     reqB,
    output logic                     reqC,
    output logic                     irq
);

    // ****************************************
    // Registers and state
    // ****************************************
    logic [LINES_A-1:0]   groupALineFallEn;
    logic [LINES_A-1:0]   groupALineRiseEn;
    logic [LINES_B-1:0]   groupBLineFallEn;
    logic [LINES_B-1:0]   groupBLineRiseEn;
    logic [LINES_C-1:0]   groupCLineFallEn;
    logic [LINES_C-1:0]   groupCLineRiseEn;
    logic                 groupARequestFlag;
    logic                 groupBRequestFlag;
    logic                 groupCRequestFlag;
    logic                 groupCIrqEnable;
    logic [STAT_W-1:0]    status;
    logic [STAT_W-1:0]    mask;
    logic [LINES_ALL-1:0] pinS1;
    logic [LINES_ALL-1:0] pinS2;
    logic [LINES_ALL-1:0] pinS3;
    logic [1:0]           settle;
    logic                 warm;
    logic [LINES_ALL-1:0] riseAll;
    logic [LINES_ALL-1:0] fallAll;
    logic [LINES_ALL-1:0] lineHit;
    logic                 setA;
    logic                 setB;
    logic                 setC;
    logic                 wrStrobe;
    logic                 mapped;
    logic [31:0]          next_prdata;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == {2'h0, idx, 2'h0};
    endfunction : hit

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    // Settle count hides the false edge of a pin that is high at release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinS1  <= '0;
            pinS2  <= '0;
            pinS3  <= '0;
            settle <= 2'h0;
        end else begin
            pinS1 <= {extGroupC, extGroupB, extGroupA};
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            if (settle != SETTLE_CYCLES) begin
                settle <= settle + 2'h1;
            end
        end
    end

    assign warm    = (settle == SETTLE_CYCLES);
    assign riseAll = {groupCLineRiseEn, groupBLineRiseEn, groupALineRiseEn};
    assign fallAll = {groupCLineFallEn, groupBLineFallEn, groupALineFallEn};

    // Each line fires on either armed direction, so both set means dual edge
    for (genvar i = 0; i < LINES_ALL; i++) begin : g_line
        assign lineHit[i] = warm & ((pinS2[i] & ~pinS3[i] & riseAll[i])
                                  | (~pinS2[i] & pinS3[i] & fallAll[i]));
    end

    assign setA = |lineHit[LINES_A-1:0];
    assign setB = |lineHit[LINES_A+LINES_B-1:LINES_A];
    assign setC = |lineHit[LINES_ALL-1:LINES_A+LINES_B];

    // ****************************************
    // APB access
    // ****************************************
    assign wrStrobe = psel & penable & pwrite & pready & ~pslverr & pstrb[0];
    assign mapped   = hit(paddr, IDX_FALL_A) | hit(paddr, IDX_RISE_A)
                    | hit(paddr, IDX_FALL_B) | hit(paddr, IDX_RISE_B)
                    | hit(paddr, IDX_FALL_C) | hit(paddr, IDX_RISE_C)
                    | hit(paddr, IDX_FLAGS)  | hit(paddr, IDX_IRQ_EN2)
                    | hit(paddr, IDX_STATUS) | hit(paddr, IDX_MASK);

    always_comb begin
        next_prdata = '0;
        if (hit(paddr, IDX_FALL_A)) next_prdata[LINES_A-1:0] = groupALineFallEn;
        if (hit(paddr, IDX_RISE_A)) next_prdata[LINES_A-1:0] = groupALineRiseEn;
        if (hit(paddr, IDX_FALL_B)) next_prdata[LINES_B-1:0] = groupBLineFallEn;
        if (hit(paddr, IDX_RISE_B)) next_prdata[LINES_B-1:0] = groupBLineRiseEn;
        if (hit(paddr, IDX_FALL_C)) next_prdata[LINES_C-1:0] = groupCLineFallEn;
        if (hit(paddr, IDX_RISE_C)) next_prdata[LINES_C-1:0] = groupCLineRiseEn;
        if (hit(paddr, IDX_FLAGS)) begin
            next_prdata[FLAG_A_BIT] = groupARequestFlag;
            next_prdata[FLAG_B_BIT] = groupBRequestFlag;
        end
        if (hit(paddr, IDX_IRQ_EN2)) next_prdata[EN_C_BIT] = groupCIrqEnable;
        if (hit(paddr, IDX_STATUS))  next_prdata[STAT_W-1:0] = status;
        if (hit(paddr, IDX_MASK))    next_prdata[STAT_W-1:0] = mask;
    end

    // No wait state: answer is prepared in the setup cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // ****************************************
    // Edge enable registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            groupALineFallEn <= ENABLE_RESET[LINES_A-1:0];
            groupALineRiseEn <= ENABLE_RESET[LINES_A-1:0];
            groupBLineFallEn <= ENABLE_RESET[LINES_B-1:0];
            groupBLineRiseEn <= ENABLE_RESET[LINES_B-1:0];
            groupCLineFallEn <= ENABLE_RESET[LINES_C-1:0];
            groupCLineRiseEn <= ENABLE_RESET[LINES_C-1:0];
            groupCIrqEnable  <= ENABLE_RESET[EN_C_BIT];
            mask             <= ENABLE_RESET[STAT_W-1:0];
        end else if (wrStrobe) begin
            if (hit(paddr, IDX_FALL_A)) groupALineFallEn <= pwdata[LINES_A-1:0];
            if (hit(paddr, IDX_RISE_A)) groupALineRiseEn <= pwdata[LINES_A-1:0];
            if (hit(paddr, IDX_FALL_B)) groupBLineFallEn <= pwdata[LINES_B-1:0];
            if (hit(paddr, IDX_RISE_B)) groupBLineRiseEn <= pwdata[LINES_B-1:0];
            if (hit(paddr, IDX_FALL_C)) groupCLineFallEn <= pwdata[LINES_C-1:0];
            if (hit(paddr, IDX_RISE_C)) groupCLineRiseEn <= pwdata[LINES_C-1:0];
            if (hit(paddr, IDX_IRQ_EN2)) groupCIrqEnable <= pwdata[EN_C_BIT];
            if (hit(paddr, IDX_MASK))    mask <= pwdata[STAT_W-1:0];
        end
    end

    // ****************************************
    // Group request flags
    // ****************************************
    // A new edge beats the acknowledge of the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            groupARequestFlag <= 1'b0;
            groupBRequestFlag <= 1'b0;
            groupCRequestFlag <= 1'b0;
        end else begin
            if (setA) begin
                groupARequestFlag <= 1'b1;
            end else if (ackA) begin
                groupARequestFlag <= 1'b0;
            end else if (wrStrobe && hit(paddr, IDX_FLAGS)) begin
                groupARequestFlag <= pwdata[FLAG_A_BIT];
            end
            if (setB) begin
                groupBRequestFlag <= 1'b1;
            end else if (ackB) begin
                groupBRequestFlag <= 1'b0;
            end else if (wrStrobe && hit(paddr, IDX_FLAGS)) begin
                groupBRequestFlag <= pwdata[FLAG_B_BIT];
            end
            if (setC) begin
                groupCRequestFlag <= 1'b1;
            end else if (ackC) begin
                groupCRequestFlag <= 1'b0;
            end
        end
    end

    assign reqA = groupARequestFlag;
    assign reqB = groupBRequestFlag;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reqC <= 1'b0;
        end else begin
            reqC <= groupCRequestFlag & groupCIrqEnable & ~ackC;
        end
    end

    // ****************************************
    // Sticky status, mask and interrupt line
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            if (wrStrobe && hit(paddr, IDX_STATUS)) begin
                status <= (status & ~pwdata[STAT_W-1:0]) | {setC, setB, setA};
            end else begin
                status <= status | {setC, setB, setA};
            end
            irq <= |(status & mask);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_fall_arm_a: assert property (
        (warm && |(~pinS2[3:0] & pinS3[3:0] & groupALineFallEn)) |=> groupARequestFlag)
        else $error("group A falling edge did not set flag");
    a_rise_write_a: assert property (
        (wrStrobe && hit(paddr, IDX_RISE_A)) |=> groupALineRiseEn == $past(pwdata[3:0]))
        else $error("group A rising enable write lost");
    b_fall_disarm_a: assert property (
        (warm && (pinS2[7:4] != pinS3[7:4]) && !groupBRequestFlag && !wrStrobe
         && ((~pinS2[7:4] & pinS3[7:4] & groupBLineFallEn)
           | (pinS2[7:4] & ~pinS3[7:4] & groupBLineRiseEn)) == 4'h0) |=> !groupBRequestFlag)
        else $error("disarmed group B edge set flag");
    b_rise_arm_a: assert property (
        (warm && |(pinS2[7:4] & ~pinS3[7:4] & groupBLineRiseEn)) |=> groupBRequestFlag)
        else $error("group B rising edge did not set flag");
    c_fall_arm_a: assert property (
        (warm && |(~pinS2[13:8] & pinS3[13:8] & groupCLineFallEn)) |=> status[ST_C])
        else $error("group C falling edge not seen in status");
    c_rise_arm_a: assert property (
        (warm && |(pinS2[13:8] & ~pinS3[13:8] & groupCLineRiseEn) && groupCIrqEnable
         && !ackC) ##1 (!ackC && groupCIrqEnable) |=> reqC)
        else $error("group C rising edge not forwarded");
    b_ack_clear_a: assert property (
        (ackB && !setB) |=> !reqB)
        else $error("group B flag survived acknowledge");
    a_ack_clear_a: assert property (
        (ackA && !setA) |=> !reqA)
        else $error("group A flag survived acknowledge");
    c_gate_a: assert property (
        !groupCIrqEnable |=> !reqC)
        else $error("group C request forwarded while disabled");
    dual_edge_a: assert property (
        (warm && |((pinS2[3:0] ^ pinS3[3:0]) & groupALineRiseEn & groupALineFallEn))
        |=> groupARequestFlag && status[ST_A])
        else $error("dual-edge line missed an edge");

    // Bus handshake, flag priority and interrupt line
    a_set_wins_a: assert property (
        setA |=> groupARequestFlag)
        else $error("group A edge lost against acknowledge");
    b_set_wins_a: assert property (
        setB |=> groupBRequestFlag)
        else $error("group B edge lost against acknowledge");
    c_req_en_a: assert property (
        reqC |-> $past(groupCIrqEnable))
        else $error("group C request without enable");
    sync_depth_a: assert property (
        warm |-> (pinS2 ^ pinS3) == ($past({extGroupC, extGroupB, extGroupA}, 2)
                                   ^ $past({extGroupC, extGroupB, extGroupA}, 3)))
        else $error("pin edge not seen two flops late");
    irq_follow_a: assert property (
        (|(status & mask)) |=> irq)
        else $error("unmasked status did not raise interrupt");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");
    unmapped_drop_a: assert property (
        (psel && penable && pready && pslverr && pwrite) |=> $stable(groupALineFallEn))
        else $error("unmapped write changed an enable");
    status_clear_a: assert property (
        (wrStrobe && hit(paddr, IDX_STATUS) && !setC && pwdata[ST_C]) |=> !status[ST_C])
        else $error("status bit survived its clear");

endmodule : ext_irq_edge_select

/* File: sim/ext_pin_model.sv */
`timescale 1ns/1ps
module ext_pin_model
    import ext_irq_pkg::*;
(
    // Clock
    input  wire logic                 sys_clk,
    // Levels asked for by the bench
    input  wire logic [LINES_ALL-1:0] want,
    // External pins
    output logic      [LINES_ALL-1:0] pins
);
    int lag   = 0;
    int waitN = 0;

    initial pins = '0;

    // Off-chip drivers follow late, by a random 0..3 cycles
    always @(posedge sys_clk) begin
        if (want === pins) begin
            lag <= 0;
        end else if (lag >= waitN) begin
            pins  <= want;
            lag   <= 0;
            waitN <= $urandom_range(3);
        end else begin
            lag <= lag + 1;
        end
    end
endmodule : ext_pin_model

/* File: sim/ext_irq_edge_select_tb_top.sv */
`timescale 1ns/1ps
module ext_irq_edge_select_tb_top;
    import ext_irq_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic                 sys_clk = 1'b0;
    logic                 resetn  = 1'b0;
    logic                 psel    = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite  = 1'b0;
    logic [ADDR_W-1:0]    paddr   = '0;
    logic [31:0]          pwdata  = '0;
    logic [2:0]           ack     = 3'h0;
    logic [LINES_ALL-1:0] want    = '0;
    logic [LINES_ALL-1:0] pins;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [2:0]           reqs;
    logic                 irq;
    logic [32:0]          expQ[$];
    int                   num_errors  = 0;
    int                   comparisons = 0;
    localparam logic [7:0] FALL_IDX [3] = '{IDX_FALL_A, IDX_FALL_B, IDX_FALL_C};
    localparam logic [7:0] RISE_IDX [3] = '{IDX_RISE_A, IDX_RISE_B, IDX_RISE_C};
    localparam logic [7:0] LINE_MSK [3] = '{8'h0F, 8'h0F, 8'h3F};
    localparam logic [7:0] FLAG_VAL [3] = '{8'h02, 8'h08, 8'h00};
    localparam int         PIN_OFF  [3] = '{0, 4, 8};

    always #5 sys_clk = ~sys_clk;

    ext_irq_edge_select u_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extGroupA(pins[LINES_A-1:0]), .extGroupB(pins[LINES_A+LINES_B-1:LINES_A]),
        .extGroupC(pins[LINES_ALL-1:LINES_A+LINES_B]), .ackA(ack[0]), .ackB(ack[1]),
        .ackC(ack[2]), .reqA(reqs[0]), .reqB(reqs[1]), .reqC(reqs[2]), .irq(irq));

    ext_pin_model u_pins (.sys_clk(sys_clk), .want(want), .pins(pins));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ADDR_W'({idx, 2'b00});
        pwdata  <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check("pready wait", 33'h0, 33'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
        expQ.push_back(exp);
        apb(1'b0, idx, 32'h0);
    endtask : rd

    // Checks follow at the falling edge so that clocked updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle

    task automatic drive_pin(input int g, input int ln, input logic v);
        @(posedge sys_clk);
        want[PIN_OFF[g]+ln] <= v;
        settle(12);
    endtask : drive_pin

    task automatic pulse_ack(input int g);
        @(posedge sys_clk);
        ack[g] <= 1'b1;
        @(posedge sys_clk);
        ack[g] <= 1'b0;
        settle(3);
    endtask : pulse_ack

    // Read answers are matched against the oldest note
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expQ.size() == 0) check("unexpected read", 33'h0, 33'h1);
            else check("read data", {pslverr, prdata}, expQ.pop_front());
        end
    end

    initial begin
        #200000;
        check("watchdog", 33'h0, 33'h1);
        finish_test();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int         ln;
        logic [7:0] v;
        logic [7:0] lbit;
        void'($urandom(32));
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            rd(FALL_IDX[g], 33'h0);
            rd(RISE_IDX[g], 33'h0);
            v = 8'($urandom()) & LINE_MSK[g];
            apb(1'b1, FALL_IDX[g], {24'h0, v});
            rd(FALL_IDX[g], {25'h0, v});
            v = 8'($urandom()) & LINE_MSK[g];
            apb(1'b1, RISE_IDX[g], {24'h0, v});
            rd(RISE_IDX[g], {25'h0, v});
        end
        rd(8'h01, {1'b1, 32'h0});
        apb(1'b1, 8'h01, 32'h0000_00FF);
        apb(1'b1, IDX_IRQ_EN2, 32'h8);
        apb(1'b1, IDX_MASK, 32'h7);
        for (int g = 0; g < 3; g++) begin
            ln   = $urandom_range(g == 2 ? 5 : 3);
            lbit = 8'h01 << ln;
            apb(1'b1, FALL_IDX[g], 32'h0);
            apb(1'b1, RISE_IDX[g], {24'h0, lbit});
            drive_pin(g, ln, 1'b1);
            check("request", reqs[g], 33'h1);
            check("irq", irq, 33'h1);
            rd(IDX_FLAGS, {25'h0, FLAG_VAL[g]});
            rd(IDX_STATUS, 33'(1 << g));
            pulse_ack(g);
            check("request", reqs[g], 33'h0);
            apb(1'b1, IDX_STATUS, 32'(1 << g));
            settle(3);
            check("irq", irq, 33'h0);
            drive_pin(g, ln, 1'b0);
            check("request", reqs[g], 33'h0);
            apb(1'b1, FALL_IDX[g], {24'h0, lbit});
            drive_pin(g, ln, 1'b1);
            check("request", reqs[g], 33'h1);
            pulse_ack(g);
            drive_pin(g, ln, 1'b0);
            check("request", reqs[g], 33'h1);
            pulse_ack(g);
            apb(1'b1, IDX_STATUS, 32'h7);
        end
        // Software may set and clear the group A and B flags directly
        apb(1'b1, IDX_FLAGS, 32'h0000_000A);
        rd(IDX_FLAGS, 33'h0A);
        apb(1'b1, IDX_FLAGS, 32'h0);
        rd(IDX_FLAGS, 33'h0);
        // Group C gated off and all masked: status still records the edge
        apb(1'b1, IDX_IRQ_EN2, 32'h0);
        apb(1'b1, IDX_MASK, 32'h0);
        drive_pin(2, ln, 1'b1);
        check("request", reqs[2], 33'h0);
        check("irq", irq, 33'h0);
        rd(IDX_STATUS, 33'h4);
        settle(2);
        check("reads left", 33'(expQ.size()), 33'h0);
        finish_test();
    end
endmodule : ext_irq_edge_select_tb_top
